// ### rtl/dds_primary_control_register.sv
// Primary and secondary control words of the synthesizer and the controls they steer
// What this block does
// R01 - Bit 26 adds timer reload on transfer strobe
// R02 - Bit 25 enables keying; bit 24 picks mode
// R03 - Manual keying multiplies samples by scale
// R04 - Auto keying ramps scale with keying pin
// R05 - Bit 23 enables automatic sync alignment
// R06 - Bit 22 advances sync edge, self-clears
// R07 - Bit 13 clears accumulator on strobe
// R08 - Bit 12 selects sine, else cosine
// R09 - Bit 10 holds accumulator clear
// R10 - Bit 9 makes data pin input only
// R11 - Bit 8 selects least significant first
// R12 - Bit 7 suspends digital except serial port
// R13 - Bit 5 powers down the converter
// R14 - Bit 4 powers down clock input
// R15 - Bit 3 low: pin downs digital only
// R16 - Bit 3 high: pin downs everything
// R17 - Bit 1 forces sync clock output low
// R18 - Host writes bit 0 as zero
// R19 - Multiplier codes 4 to 20 multiply
// R20 - Scale low 14 bits max, top two step
// R21 - Eight-bit ramp rate sets step rate
// R22 - Reset clears every primary word bit
`timescale 1ns/100ps
module dds_primary_control_register
    import dds_ctrl_pkg::*;
#(
    parameter int SAMPLE_WIDTH = 14
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // Register port from the serial engine
    input  wire logic                    wr_en_i,
    input  wire logic [7:0]              wr_addr_i,
    input  wire logic [31:0]             wr_data_i,
    input  wire logic [7:0]              rd_addr_i,
    output logic      [31:0]             rd_data_o,
    input  wire logic                    update_i,
    // Keying inputs and scaled sample output
    input  wire logic                    keying_pin_i,
    input  wire logic [15:0]             amplitude_scale_i,
    input  wire logic [RATE_WIDTH-1:0]   ramp_rate_value_i,
    input  wire logic [SAMPLE_WIDTH-1:0] sample_i,
    output logic      [SAMPLE_WIDTH-1:0] scaled_sample_o,
    // Sync and accumulator controls
    input  wire logic                    align_pin_i,
    input  wire logic                    sync_clk_int_i,
    output logic                         auto_sync_en_o,
    output logic                         align_sample_o,
    output logic                         sync_advance_o,
    output logic                         sync_clk_o,
    output logic                         accum_clear_o,
    output logic                         sine_select_o,
    // Serial port format
    output logic                         data_pin_input_only_o,
    output logic                         lsb_first_o,
    // Power controls
    input  wire logic                    power_down_pin_i,
    output logic                         digital_suspend_o,
    output logic                         converter_pd_o,
    output logic                         clock_input_pd_o,
    output logic                         analog_pd_o,
    // Reference multiplier
    output logic                         mult_bypass_o,
    output logic      [4:0]              mult_factor_o
);

    logic [31:0]            primary_control_word;
    logic [23:0]            secondary_control_word;
    logic [31:0]            next_primary;
    logic [SCALE_WIDTH-1:0] ramp_scale;
    logic [SCALE_WIDTH-1:0] gain;
    logic                   key_on;
    logic                   key_auto;
    logic                   run;
    logic                   pin_down;
    logic [4:0]             mult_code;
    logic [SAMPLE_WIDTH+SCALE_WIDTH-1:0] product;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_comb begin
        next_primary = primary_control_word;
        if (primary_control_word[MANUAL_SYNC_BIT]) begin
            next_primary[MANUAL_SYNC_BIT] = 1'b0; // R06
        end
        if (wr_en_i && wr_addr_i == PRIMARY_CONTROL_ADDR) begin
            // Bit 0 and unused bits are forced to zero
            next_primary = wr_data_i & PRIMARY_WRITE_MASK; // R18
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            primary_control_word <= PRIMARY_RESET; // R22
        end else begin
            primary_control_word <= next_primary;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            secondary_control_word <= SECONDARY_RESET;
        end else if (wr_en_i && wr_addr_i == SECONDARY_CONTROL_ADDR) begin
            secondary_control_word <= wr_data_i[23:0];
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_data_o <= '0;
        end else begin
            unique case (rd_addr_i)
                PRIMARY_CONTROL_ADDR:   rd_data_o <= primary_control_word;
                SECONDARY_CONTROL_ADDR: rd_data_o <= {8'h00, secondary_control_word};
                default:                rd_data_o <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Power control
    // ------------------------------------------------------------
    assign pin_down = power_down_pin_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            digital_suspend_o <= 1'b0;
            converter_pd_o    <= 1'b0;
            clock_input_pd_o  <= 1'b0;
            analog_pd_o       <= 1'b0;
        end else begin
            // Pin power-down always stops digital logic
            digital_suspend_o <= primary_control_word[DIGITAL_PD_BIT] || pin_down; // R12 R15
            converter_pd_o    <= primary_control_word[CONVERTER_PD_BIT]
                                 || (pin_down && primary_control_word[FULL_PD_BIT]); // R13 R16
            clock_input_pd_o  <= primary_control_word[CLOCK_IN_PD_BIT]
                                 || (pin_down && primary_control_word[FULL_PD_BIT]); // R14 R16
            analog_pd_o       <= pin_down && primary_control_word[FULL_PD_BIT]; // R15 R16
        end
    end

    assign run = !digital_suspend_o && !clock_input_pd_o;

    // ------------------------------------------------------------
    // Amplitude keying
    // ------------------------------------------------------------
    assign key_on   = primary_control_word[KEY_ENABLE_BIT];
    assign key_auto = primary_control_word[KEY_AUTO_BIT];

    keying_ramp u_ramp (
        .clk_i              (clk_i),
        .rst_i              (rst_i),
        .run_i              (run && key_on && key_auto),
        .key_i              (keying_pin_i),
        .update_i           (update_i),
        .reload_on_update_i (primary_control_word[RAMP_LOAD_BIT]),
        .max_i              (amplitude_scale_i[SCALE_WIDTH-1:0]),
        .step_sel_i         (amplitude_scale_i[STEP_LSB+1:STEP_LSB]),
        .rate_i             (ramp_rate_value_i),
        .scale_o            (ramp_scale)
    );

    assign gain    = key_auto ? ramp_scale : amplitude_scale_i[SCALE_WIDTH-1:0]; // R03 R04
    assign product = sample_i * gain;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scaled_sample_o <= '0;
        end else if (!run) begin
            scaled_sample_o <= scaled_sample_o;
        end else if (!key_on) begin
            scaled_sample_o <= sample_i; // R02
        end else begin
            scaled_sample_o <= product[SAMPLE_WIDTH+SCALE_WIDTH-1:SCALE_WIDTH]; // R02
        end
    end

    // ------------------------------------------------------------
    // Sync, accumulator and conversion controls
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            auto_sync_en_o <= 1'b0;
            align_sample_o <= 1'b0;
            sync_advance_o <= 1'b0;
            sync_clk_o     <= 1'b0;
            accum_clear_o  <= 1'b0;
            sine_select_o  <= 1'b0;
        end else begin
            auto_sync_en_o <= primary_control_word[AUTO_SYNC_BIT]; // R05
            align_sample_o <= primary_control_word[AUTO_SYNC_BIT] && align_pin_i; // R05
            sync_advance_o <= primary_control_word[MANUAL_SYNC_BIT]; // R06
            sync_clk_o     <= sync_clk_int_i && !primary_control_word[SYNC_OUT_OFF_BIT]; // R17
            accum_clear_o  <= primary_control_word[CLEAR_ACCUM_BIT]
                              || (primary_control_word[AUTO_CLEAR_BIT] && update_i); // R07 R09
            sine_select_o  <= primary_control_word[SINE_SELECT_BIT]; // R08
        end
    end

    // ------------------------------------------------------------
    // Serial format and reference multiplier
    // ------------------------------------------------------------
    assign data_pin_input_only_o = primary_control_word[INPUT_ONLY_BIT]; // R10
    assign lsb_first_o           = primary_control_word[LSB_FIRST_BIT]; // R11

    assign mult_code = secondary_control_word[MULT_MSB:MULT_LSB];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mult_bypass_o <= 1'b1;
            mult_factor_o <= '0;
        end else begin
            mult_bypass_o <= (mult_code < MULT_MIN) || (mult_code > MULT_MAX); // R19
            mult_factor_o <= mult_code;
        end
    end

endmodule

// ### rtl/dds_ctrl_pkg.sv
// Package: register map, field positions and constants of the synthesizer control word
package dds_ctrl_pkg;

    localparam logic [7:0]  PRIMARY_CONTROL_ADDR   = 8'h00;
    localparam logic [7:0]  SECONDARY_CONTROL_ADDR = 8'h01;
    localparam logic [31:0] PRIMARY_RESET          = 32'h0000_0000;
    localparam logic [23:0] SECONDARY_RESET        = 24'h00_0000;
    // Writable bits of the primary word; unused bits stay zero
    localparam logic [31:0] PRIMARY_WRITE_MASK     = 32'h07C0_37BA;

    localparam int RAMP_LOAD_BIT    = 26;
    localparam int KEY_ENABLE_BIT   = 25;
    localparam int KEY_AUTO_BIT     = 24;
    localparam int AUTO_SYNC_BIT    = 23;
    localparam int MANUAL_SYNC_BIT  = 22;
    localparam int AUTO_CLEAR_BIT   = 13;
    localparam int SINE_SELECT_BIT  = 12;
    localparam int CLEAR_ACCUM_BIT  = 10;
    localparam int INPUT_ONLY_BIT   = 9;
    localparam int LSB_FIRST_BIT    = 8;
    localparam int DIGITAL_PD_BIT   = 7;
    localparam int CONVERTER_PD_BIT = 5;
    localparam int CLOCK_IN_PD_BIT  = 4;
    localparam int FULL_PD_BIT      = 3;
    localparam int SYNC_OUT_OFF_BIT = 1;

    localparam int MULT_LSB = 3;
    localparam int MULT_MSB = 7;
    localparam logic [4:0] MULT_MIN = 5'h04;
    localparam logic [4:0] MULT_MAX = 5'h14;

    localparam int SCALE_WIDTH = 14;
    localparam int STEP_LSB    = 14;
    localparam int RATE_WIDTH  = 8;
    localparam logic [7:0] TIMER_TIMEOUT = 8'h01;

endpackage

// ### rtl/keying_ramp.sv
// Automatic keying ramp: scale counter stepped by a reloadable rate timer
`timescale 1ns/100ps
module keying_ramp
    import dds_ctrl_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   run_i,
    input  wire logic                   key_i,
    input  wire logic                   update_i,
    input  wire logic                   reload_on_update_i,
    input  wire logic [SCALE_WIDTH-1:0] max_i,
    input  wire logic [1:0]             step_sel_i,
    input  wire logic [RATE_WIDTH-1:0]  rate_i,
    output logic      [SCALE_WIDTH-1:0] scale_o
);

    logic [RATE_WIDTH-1:0]  timer;
    logic [SCALE_WIDTH:0]   step;
    logic [SCALE_WIDTH:0]   up_sum;
    logic                   tick;

    assign tick   = run_i && (timer == TIMER_TIMEOUT);
    assign step   = (SCALE_WIDTH+1)'(1) << step_sel_i;
    assign up_sum = {1'b0, scale_o} + step;

    // ------------------------------------------------------------
    // Rate timer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            timer <= TIMER_TIMEOUT;
        end else if (tick || (reload_on_update_i && update_i)) begin // R01
            timer <= rate_i; // R21
        end else if (timer > TIMER_TIMEOUT) begin
            timer <= timer - 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Scale counter
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            scale_o <= '0;
        end else if (tick) begin
            if (key_i) begin // R04
                scale_o <= (up_sum >= {1'b0, max_i}) ? max_i : up_sum[SCALE_WIDTH-1:0]; // R20
            end else begin
                scale_o <= ({1'b0, scale_o} <= step) ? '0 : scale_o - step[SCALE_WIDTH-1:0];
            end
        end
    end

endmodule

// ### verification/dds_ctrl_assertions.sv
// Checker: port-level properties of the control word block
`timescale 1ns/100ps
module dds_ctrl_assert
    import dds_ctrl_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [7:0]  rd_addr_i,
    input wire logic [31:0] rd_data_o,
    input wire logic        align_pin_i,
    input wire logic        sync_clk_int_i,
    input wire logic        power_down_pin_i,
    input wire logic        auto_sync_en_o,
    input wire logic        align_sample_o,
    input wire logic        sync_advance_o,
    input wire logic        sync_clk_o,
    input wire logic        digital_suspend_o,
    input wire logic        converter_pd_o,
    input wire logic        clock_input_pd_o,
    input wire logic        analog_pd_o,
    input wire logic        mult_bypass_o,
    input wire logic [4:0]  mult_factor_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_adv_pulse: assert property (sync_advance_o |=> !sync_advance_o)
        else $error("advance pulse too long");
    a_sync_gate: assert property (sync_clk_o |-> $past(sync_clk_int_i))
        else $error("sync out without source");
    a_align_gate: assert property (align_sample_o |-> auto_sync_en_o && $past(align_pin_i))
        else $error("align sample ungated");
    a_full_pd: assert property (analog_pd_o |-> converter_pd_o && clock_input_pd_o && digital_suspend_o)
        else $error("partial full power down");
    a_pd_cause: assert property (analog_pd_o |-> $past(power_down_pin_i))
        else $error("analog down without pin");
    a_pin_digital: assert property ($past(power_down_pin_i) && !$past(rst_i) |-> digital_suspend_o)
        else $error("pin did not suspend digital");
    a_mult_code: assert property (mult_bypass_o == (mult_factor_o < MULT_MIN || mult_factor_o > MULT_MAX))
        else $error("bypass disagrees with code");
    a_unused_zero: assert property (rd_addr_i == PRIMARY_CONTROL_ADDR |=> (rd_data_o & ~PRIMARY_WRITE_MASK) == 32'h0)
        else $error("unused bit reads one");
endmodule

bind dds_primary_control_register dds_ctrl_assert chk (
    .clk_i(clk_i), .rst_i(rst_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .align_pin_i(align_pin_i),
    .sync_clk_int_i(sync_clk_int_i), .power_down_pin_i(power_down_pin_i), .auto_sync_en_o(auto_sync_en_o),
    .align_sample_o(align_sample_o), .sync_advance_o(sync_advance_o), .sync_clk_o(sync_clk_o),
    .digital_suspend_o(digital_suspend_o), .converter_pd_o(converter_pd_o), .clock_input_pd_o(clock_input_pd_o),
    .analog_pd_o(analog_pd_o), .mult_bypass_o(mult_bypass_o), .mult_factor_o(mult_factor_o)
);

// ### verification/host_model.sv
// Host model: drives the register port as the serial engine would
`timescale 1ns/100ps
module host_model (
    input  wire logic        clk_i,
    input  wire logic [31:0] rd_data_i,
    output logic             wr_en_o = 1'b0,
    output logic      [7:0]  wr_addr_o = 8'h00,
    output logic      [31:0] wr_data_o = 32'h0,
    output logic      [7:0]  rd_addr_o = 8'h00,
    output logic             update_o = 1'b0
);
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_en_o <= 1'b1;
        wr_addr_o <= a;
        wr_data_o <= d & 32'hFFFF_FFFE;
        @(posedge clk_i);
        wr_en_o <= 1'b0;
        wr_data_o <= ~wr_data_o;
    endtask
    task automatic strobe();
        @(posedge clk_i);
        update_o <= 1'b1;
        @(posedge clk_i);
        update_o <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        rd_addr_o <= a;
        @(posedge clk_i);
        @(posedge clk_i);
        #1 d = rd_data_i;
    endtask
endmodule

// ### verification/tb_top.sv
// Testbench: register, control and keying checks of the control block
`timescale 1ns/100ps
module tb_top import dds_ctrl_pkg::*;;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        key = 1'b0;
    logic        pd_pin = 1'b0;
    logic [15:0] scale = 16'h0;
    logic [13:0] sample = 14'h1234;
    logic [13:0] scaled;
    logic        wr_en, update, sync_clk, adv, clr, bypass, apd;
    logic [7:0]  wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data, r;
    logic [4:0]  factor;
    logic [7:0]  flags;
    logic [7:0]  rate = 8'h02;
    logic [7:0]  n_adv = 8'h00;
    logic [7:0]  n_clr = 8'h00;
    logic [7:0]  base;
    logic [4:0]  codes [4] = '{5'h03, 5'h04, 5'h14, 5'h15};
    int          fails = 0;
    int          checks_done = 0;

    dds_primary_control_register uut (
        .clk_i(clk_i), .rst_i(rst_i), .wr_en_i(wr_en), .wr_addr_i(wr_addr), .wr_data_i(wr_data),
        .rd_addr_i(rd_addr), .rd_data_o(rd_data), .update_i(update), .keying_pin_i(key),
        .amplitude_scale_i(scale), .ramp_rate_value_i(rate), .sample_i(sample), .scaled_sample_o(scaled),
        .align_pin_i(1'b1), .sync_clk_int_i(1'b1), .auto_sync_en_o(flags[6]), .align_sample_o(flags[7]),
        .sync_advance_o(adv), .sync_clk_o(sync_clk), .accum_clear_o(clr), .sine_select_o(flags[5]),
        .data_pin_input_only_o(flags[4]), .lsb_first_o(flags[3]), .power_down_pin_i(pd_pin),
        .digital_suspend_o(flags[2]), .converter_pd_o(flags[1]), .clock_input_pd_o(flags[0]),
        .analog_pd_o(apd), .mult_bypass_o(bypass), .mult_factor_o(factor)
    );
    host_model host (.clk_i(clk_i), .rd_data_i(rd_data), .wr_en_o(wr_en), .wr_addr_o(wr_addr),
        .wr_data_o(wr_data), .rd_addr_o(rd_addr), .update_o(update));

    initial begin
        forever #20 clk_i = ~clk_i;
    end
    // Pulse counters for the one-cycle outputs
    always @(posedge clk_i) begin
        n_adv <= n_adv + {7'h00, adv};
        n_clr <= n_clr + {7'h00, clr};
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic conclude();
        if (fails == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_i);
        fails++;
        conclude();
    end
    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        host.rd(PRIMARY_CONTROL_ADDR, r);
        chk("primary reset", r, 32'h0);
        host.rd(8'h07, r);
        chk("unmapped read", r, 32'h0);
        chk("bypass at reset", {31'h0, bypass}, 32'h1);
        host.wr(PRIMARY_CONTROL_ADDR, 32'hFFFF_FFFF);
        settle(2);
        chk("flags set", {24'h0, flags}, 32'hFF);
        chk("sync out off", {31'h0, sync_clk}, 32'h0);
        host.rd(PRIMARY_CONTROL_ADDR, r);
        chk("primary ones", r, 32'h0780_37BA);
        host.wr(PRIMARY_CONTROL_ADDR, 32'h0);
        settle(2);
        chk("flags clear", {24'h0, flags}, 32'h0);
        chk("sync out on", {31'h0, sync_clk}, 32'h1);
        base = n_adv;
        host.wr(PRIMARY_CONTROL_ADDR, 32'h0040_0000);
        host.wr(PRIMARY_CONTROL_ADDR, 32'h0040_0000);
        settle(4);
        chk("advance pulses", {24'h0, n_adv - base}, 32'h2);
        for (int i = 1; i >= 0; i--) begin
            host.wr(PRIMARY_CONTROL_ADDR, i ? 32'h0000_2000 : 32'h0);
            base = n_clr;
            host.strobe();
            settle(3);
            chk("auto clear", {24'h0, n_clr - base}, i);
        end
        host.wr(PRIMARY_CONTROL_ADDR, 32'h0000_0400);
        settle(4);
        chk("hold clear", {31'h0, clr}, 32'h1);
        @(posedge clk_i);
        pd_pin <= 1'b1;
        host.wr(PRIMARY_CONTROL_ADDR, 32'h0);
        settle(2);
        chk("rapid down", {28'h0, flags[2:0], apd}, 32'h8);
        host.wr(PRIMARY_CONTROL_ADDR, 32'h0000_0008);
        settle(2);
        chk("full down", {28'h0, flags[2:0], apd}, 32'hF);
        foreach (codes[i]) begin
            host.wr(SECONDARY_CONTROL_ADDR, {24'h0, codes[i], 3'h0});
            settle(2);
            chk("multiplier", {26'h0, bypass, factor}, {26'h0, codes[i] < MULT_MIN || codes[i] > MULT_MAX, codes[i]});
        end
        host.rd(SECONDARY_CONTROL_ADDR, r);
        chk("secondary read", r, {24'h0, codes[3], 3'h0});
        @(posedge clk_i);
        pd_pin <= 1'b0;
        host.wr(PRIMARY_CONTROL_ADDR, 32'h0);
        settle(3);
        chk("keying off", {18'h0, scaled}, 32'h1234);
        @(posedge clk_i);
        scale <= 16'h2000;
        sample <= 14'h1000;
        host.wr(PRIMARY_CONTROL_ADDR, 32'h0200_0000);
        settle(3);
        chk("manual gain", {18'h0, scaled}, 32'h0800);
        @(posedge clk_i);
        scale <= 16'h0004;
        sample <= 14'h3FFF;
        key <= 1'b1;
        host.wr(PRIMARY_CONTROL_ADDR, 32'h0300_0000);
        settle(60);
        chk("ramp up", {18'h0, scaled}, 32'h0003);
        @(posedge clk_i);
        key <= 1'b0;
        settle(60);
        chk("ramp down", {18'h0, scaled}, 32'h0);
        // Strobes every other cycle hold the timer off only with reload on strobe
        @(posedge clk_i);
        key <= 1'b1;
        scale <= 16'hFFFF;
        rate <= 8'h10;
        for (int i = 1; i >= 0; i--) begin
            host.wr(PRIMARY_CONTROL_ADDR, 32'h0);
            host.wr(PRIMARY_CONTROL_ADDR, i ? 32'h0700_0000 : 32'h0300_0000);
            repeat (20) host.strobe();
            settle(2);
            chk("ramp reload", {18'h0, scaled}, i ? 32'h0007 : 32'h0017);
        end
        conclude();
    end
endmodule
